// ===== src/rsq_rail_seq.sv
// Rail six enable decision and edge delays of step-down rails five and six
// Behaviour
// R1: Rail five's enable falls after the delay coded in its bits 5:3 (0, 2, 4, 8, 16, 24, 32 or 64 ms).
// R2: Rail five's enable rises after the delay coded in its bits 2:0, same table.
// R3: Rail six's source code at bits 4:2 picks pin 1, 2, 5, 4, 3, pins 3 and 4, or pin 6.
// R4: Source code 111 feeds a constant one, so rail six needs no pin.
// R5: A mask bit of 0 lets that rail's power good gate rail six, a 1 removes it.
// R6: Mask register bits 7 to 0 stand for linear a3, a2, switch a1 and rails five to one.
// R7: Source register bit 1 masks the switch b2 / linear a1 power good, bit 0 switch b1's.
// R8: Source register bit 5 selects 10 mV steps at 0 and 25 mV steps at 1 for rail six.
// R9: Software should leave the step select alone at run time and set it only through OTP.
// R10: A rail enables only with its source true, all unmasked power goods good, after its rise delay.
// R11: All configuration bytes reset to OTP defaults and are readable and writable.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module rsq_rail_seq #(
  parameter int P_CYC_PER_MS = rsq_pkg::CYC_PER_MS
) (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [7:0]  O_RDATA,
  input  wire logic [31:0] I_OTP_DEFAULTS,
  input  wire logic [5:0]  I_CTL_PIN,
  input  wire logic [9:0]  I_POWER_GOOD,
  input  wire logic        I_RAIL5_EN_REQ,
  output logic             O_RAIL5_EN,
  output logic             O_RAIL6_EN,
  output logic             O_RAIL6_STEP_25MV
);
  import rsq_pkg::*;

  logic [7:0]  r5_dly_reg;
  logic [7:0]  r5_dly_next;
  logic [7:0]  r6_mask_reg;
  logic [7:0]  r6_mask_next;
  logic [7:0]  r6_src_reg;
  logic [7:0]  r6_src_next;
  logic [7:0]  r6_dly_reg;
  logic [7:0]  r6_dly_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;
  logic [5:0]  ctl_s;
  logic [9:0]  pg_s;
  logic [9:0]  pg_mask;
  logic        pg_ok;
  logic        src_on;
  rsq_src_e    src_code;

  rsq_dly_if r5_if ();
  rsq_dly_if r6_if ();

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Control pins and power goods are asynchronous to the reference clock
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      pin_meta_reg <= 16'h0000;
      pin_sync_reg <= 16'h0000;
    end
    else
    begin
      pin_meta_reg <= {I_POWER_GOOD, I_CTL_PIN};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign ctl_s = pin_sync_reg[5:0];
  assign pg_s  = pin_sync_reg[15:6];

  // ****************************************
  // Register file
  // ****************************************
  always_comb
  begin
    r5_dly_next  = r5_dly_reg;
    r6_mask_next = r6_mask_reg;
    r6_src_next  = r6_src_reg;
    r6_dly_next  = r6_dly_reg;
    rdata_next   = 8'h00;
    if (I_WR)
    begin
      case (I_ADDR)
        RAIL5_DELAY_OFS:  r5_dly_next  = I_WDATA; // R11
        RAIL6_MASK_OFS:   r6_mask_next = I_WDATA; // R11
        RAIL6_SOURCE_OFS: r6_src_next  = I_WDATA; // R11
        RAIL6_DELAY_OFS:  r6_dly_next  = I_WDATA; // R11
        default:          r5_dly_next  = r5_dly_reg;
      endcase
    end
    if (I_RD)
    begin
      case (I_ADDR)
        RAIL5_DELAY_OFS:  rdata_next = r5_dly_reg;
        RAIL6_MASK_OFS:   rdata_next = r6_mask_reg;
        RAIL6_SOURCE_OFS: rdata_next = r6_src_reg;
        RAIL6_DELAY_OFS:  rdata_next = r6_dly_reg;
        STATUS_OFS:       rdata_next = {3'h0, r6_if.busy, r5_if.busy, src_on & pg_ok, r6_if.en, r5_if.en};
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  // Synchronous reset, so loading the OTP image here is a clocked capture
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      r5_dly_reg  <= I_OTP_DEFAULTS[OTP_RAIL5_DELAY_LSB +: 8]; // R11
      r6_mask_reg <= I_OTP_DEFAULTS[OTP_RAIL6_MASK_LSB +: 8]; // R11
      r6_src_reg  <= I_OTP_DEFAULTS[OTP_RAIL6_SOURCE_LSB +: 8]; // R11
      r6_dly_reg  <= I_OTP_DEFAULTS[OTP_RAIL6_DELAY_LSB +: 8]; // R11
      rdata_reg   <= 8'h00;
    end
    else
    begin
      r5_dly_reg  <= r5_dly_next;
      r6_mask_reg <= r6_mask_next;
      r6_src_reg  <= r6_src_next;
      r6_dly_reg  <= r6_dly_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;

  // ****************************************
  // Rail six enable decision
  // ****************************************
  assign src_code = rsq_src_e'(r6_src_reg[SOURCE_CODE_LSB +: 3]);

  always_comb
  begin
    case (src_code) // R3
      SRC_PIN1:   src_on = ctl_s[0];
      SRC_PIN2:   src_on = ctl_s[1];
      SRC_PIN5:   src_on = ctl_s[4];
      SRC_PIN4:   src_on = ctl_s[3];
      SRC_PIN3:   src_on = ctl_s[2];
      SRC_PIN3_4: src_on = ctl_s[2] & ctl_s[3];
      SRC_PIN6:   src_on = ctl_s[5];
      SRC_ALWAYS: src_on = 1'b1; // R4
      default:    src_on = 1'b1;
    endcase
  end

  // Power good order: rails 1-5, switch a1, linear a2, linear a3, switch b1, b2/a1 combo
  assign pg_mask = {r6_src_reg[MASK_COMBO_BIT], r6_src_reg[MASK_B1_BIT], r6_mask_reg}; // R6 R7
  assign pg_ok   = &(pg_s | pg_mask); // R5

  assign r6_if.req       = src_on & pg_ok; // R10
  assign r6_if.rise_code = r6_dly_reg[RISE_CODE_LSB +: 3];
  assign r6_if.fall_code = r6_dly_reg[FALL_CODE_LSB +: 3];

  // Rail five's source and mask selection live outside this block
  assign r5_if.req       = I_RAIL5_EN_REQ;
  assign r5_if.rise_code = r5_dly_reg[RISE_CODE_LSB +: 3]; // R2
  assign r5_if.fall_code = r5_dly_reg[FALL_CODE_LSB +: 3]; // R1

  rsq_edge_delay #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_rail5_delay (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .bus     (r5_if.unit)
  );

  rsq_edge_delay #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_rail6_delay (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .bus     (r6_if.unit)
  );

  assign O_RAIL5_EN = r5_if.en;
  assign O_RAIL6_EN = r6_if.en;
  // Changing the step select with the rail live shifts its voltage at once
  assign O_RAIL6_STEP_25MV = r6_src_reg[STEP_SELECT_BIT]; // R8

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  // Checks against the raw pin two edges back, so the synchroniser depth is covered too
  pin1_source_a: assert property (src_code == SRC_PIN1 && $past(I_RST_N) && $past(I_RST_N, 2) // R3
    |-> r6_if.req == ($past(I_CTL_PIN[0], 2) & pg_ok))
    else $error("pin 1 source not followed");

  pin34_source_a: assert property (src_code == SRC_PIN3_4 && !(ctl_s[2] && ctl_s[3]) |-> !r6_if.req) // R3
    else $error("combined pins 3 and 4 not required");

  forced_source_a: assert property (src_code == SRC_ALWAYS && pg_ok |-> r6_if.req) // R4
    else $error("constant source did not request");

  full_mask_a: assert property (pg_mask == 10'h3FF |-> pg_ok) // R5
    else $error("fully masked power good still blocks");

  rail5_mask_a: assert property (!r6_mask_reg[4] && !pg_s[4] |-> !r6_if.req) // R6
    else $error("unmasked rail five power good ignored");

  switch_b1_mask_a: assert property (!r6_src_reg[MASK_B1_BIT] && !pg_s[8] |-> !r6_if.req) // R7
    else $error("unmasked switch b1 power good ignored");

  step_write_a: assert property (I_WR && I_ADDR == RAIL6_SOURCE_OFS |=> O_RAIL6_STEP_25MV == $past(I_WDATA[5])) // R8
    else $error("step select not taken from write");

  otp_load_a: assert property (@(posedge I_REF_CLK) disable iff (1'b0) // R11
    !I_RST_N |=> r6_mask_reg == $past(I_OTP_DEFAULTS[15:8]) && r5_dly_reg == $past(I_OTP_DEFAULTS[7:0]))
    else $error("OTP default not loaded");

  readback_a: assert property (I_RD && I_ADDR == RAIL6_SOURCE_OFS |=> O_RDATA == $past(r6_src_reg)) // R11
    else $error("readback differs from register");

  forced_rise_c: cover property (src_code == SRC_ALWAYS && $rose(O_RAIL6_EN));
  delayed_rise_c: cover property (r6_if.rise_code != 3'h0 && $rose(O_RAIL6_EN));
  rail5_fall_c: cover property (r5_if.fall_code != 3'h0 && $fell(O_RAIL5_EN));

endmodule // rsq_rail_seq

// ===== pkg/rsq_pkg.sv
// Constants shared by the rail enable sequencing block
package rsq_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RAIL5_DELAY_OFS  = 8'h15;
  localparam logic [7:0] RAIL6_MASK_OFS   = 8'h16;
  localparam logic [7:0] RAIL6_SOURCE_OFS = 8'h17;
  localparam logic [7:0] RAIL6_DELAY_OFS  = 8'h18;
  localparam logic [7:0] STATUS_OFS       = 8'h1F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RISE_CODE_LSB   = 0;
  localparam int FALL_CODE_LSB   = 3;
  localparam int MASK_COMBO_BIT  = 1;
  localparam int MASK_B1_BIT     = 0;
  localparam int SOURCE_CODE_LSB = 2;
  localparam int STEP_SELECT_BIT = 5;

  // Byte positions of the power-on defaults in the OTP image
  localparam int OTP_RAIL5_DELAY_LSB  = 0;
  localparam int OTP_RAIL6_MASK_LSB   = 8;
  localparam int OTP_RAIL6_SOURCE_LSB = 16;
  localparam int OTP_RAIL6_DELAY_LSB  = 24;

  // ****************************************
  // Enable source codes
  // ****************************************
  typedef enum logic [2:0] {
    SRC_PIN1   = 3'b000,
    SRC_PIN2   = 3'b001,
    SRC_PIN5   = 3'b010,
    SRC_PIN4   = 3'b011,
    SRC_PIN3   = 3'b100,
    SRC_PIN3_4 = 3'b101,
    SRC_PIN6   = 3'b110,
    SRC_ALWAYS = 3'b111
  } rsq_src_e;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // Edge delay in milliseconds for each three-bit code
  localparam logic [6:0] DLY_MS_TBL [0:7] = '{7'h00, 7'h02, 7'h04, 7'h08, 7'h10, 7'h18, 7'h20, 7'h40};

endpackage

// ===== pkg/rsq_dly_if.sv
// Request and result of one edge delay unit
`timescale 1ns/1ps
interface rsq_dly_if;
  logic       req;
  logic [2:0] rise_code;
  logic [2:0] fall_code;
  logic       en;
  logic       busy;

  modport ctrl (output req, output rise_code, output fall_code, input en, input busy);
  modport unit (input req, input rise_code, input fall_code, output en, output busy);
endinterface

// ===== src/rsq_edge_delay.sv
// Programmable rising and falling edge delay of one rail enable
`timescale 1ns/1ps
module rsq_edge_delay #(
  parameter int P_CYC_PER_MS = rsq_pkg::CYC_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  rsq_dly_if.unit  bus
);
  import rsq_pkg::*;

  localparam int PW = $clog2(P_CYC_PER_MS + 1);

  logic          out_reg;
  logic          out_next;
  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic [6:0]    ms_reg;
  logic [6:0]    ms_next;
  logic [6:0]    target;

  // ****************************************
  // Delay counter
  // ****************************************
  // Prescaler restarts with each new edge, so the delay is exact, not off by a partial millisecond
  always_comb
  begin
    target   = out_reg ? DLY_MS_TBL[bus.fall_code] : DLY_MS_TBL[bus.rise_code]; // R1 R2
    out_next = out_reg;
    pre_next = '0;
    ms_next  = '0;
    if (bus.req != out_reg)
    begin
      if (target == 7'h00)
        out_next = bus.req;
      else if (pre_reg == PW'(P_CYC_PER_MS - 1))
      begin
        // Greater-or-equal covers a code shortened while counting
        if (ms_reg >= target - 7'h01)
          out_next = bus.req; // R10
        else
          ms_next = ms_reg + 7'h01;
      end
      else
      begin
        pre_next = pre_reg + PW'(1);
        ms_next  = ms_reg;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      out_reg <= 1'b0;
      pre_reg <= '0;
      ms_reg  <= '0;
    end
    else
    begin
      out_reg <= out_next;
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
    end
  end

  assign bus.en   = out_reg;
  assign bus.busy = (bus.req != out_reg);

  // ****************************************
  // Assertions
  // ****************************************
  int wait_cnt;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || bus.req == out_reg)
      wait_cnt <= 0;
    else
      wait_cnt <= wait_cnt + 1;
  end

  rise_delay_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
    $rose(out_reg) && $stable(bus.rise_code) && $past(target) != 7'h00
    |-> $past(wait_cnt) == int'($past(target)) * P_CYC_PER_MS - 1)
    else $error("rail enable rose at the wrong time");

  fall_delay_time_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    $fell(out_reg) && $stable(bus.fall_code) && $past(target) != 7'h00
    |-> $past(wait_cnt) == int'($past(target)) * P_CYC_PER_MS - 1)
    else $error("rail enable fell at the wrong time");

  zero_fall_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
    out_reg && !bus.req && bus.fall_code == 3'h0 |=> !out_reg)
    else $error("undelayed fall did not follow next cycle");

  rise_needs_req_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
    $rose(out_reg) |-> $past(bus.req))
    else $error("rail enable rose without request");

endmodule // rsq_edge_delay

// ===== bench/rsq_host_model.sv
// Host side model: control pins, power good inputs and rail five request
`timescale 1ns/1ps
module rsq_host_model (
  input  wire logic       i_clk,
  output logic      [5:0] o_ctl_pin,
  output logic      [9:0] o_power_good,
  output logic            o_rail5_en_req
);
  initial
  begin
    o_ctl_pin      = 6'h00;
    o_power_good   = 10'h000;
    o_rail5_en_req = 1'b0;
  end

  // Levels change just after an edge; the step select is left to the OTP image
  task automatic drive(input logic [5:0] pins, input logic [9:0] pg, input logic req);
    @(posedge i_clk);
    o_ctl_pin      <= pins;
    o_power_good   <= pg;
    o_rail5_en_req <= req;
  endtask
endmodule // rsq_host_model

// ===== bench/tb_top.sv
// Self-checking bench of the rail enable sequencing block
`timescale 1ns/1ps
module tb_top;
  import rsq_pkg::*;
  localparam int          P     = 10;
  localparam logic [31:0] OTP_A = 32'h5AA63C12;
  localparam logic [31:0] OTP_B = 32'h5A863C12;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [31:0] otp;
  logic [5:0]  pins;
  logic [9:0]  pg;
  logic        req5;
  logic        en5;
  logic        en6;
  logic        step;
  logic [7:0]  d;
  int          n;
  int          num_errors;
  int          checks_done;

  rsq_host_model host (.i_clk(clk), .o_ctl_pin(pins), .o_power_good(pg), .o_rail5_en_req(req5));

  rsq_rail_seq #(.P_CYC_PER_MS(P)) dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_OTP_DEFAULTS(otp), .I_CTL_PIN(pins), .I_POWER_GOOD(pg),
    .I_RAIL5_EN_REQ(req5), .O_RAIL5_EN(en5), .O_RAIL6_EN(en6), .O_RAIL6_STEP_25MV(step));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic do_reset(input logic [31:0] v);
    @(posedge clk);
    otp   <= v;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Edges until the chosen enable shows exp; a hang ends the run
  task automatic wait_en(input bit six, input logic exp, input int lim, output int cnt);
    cnt = 0;
    while (((six ? en6 : en5) !== exp) && cnt < lim)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= lim)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, !exp, exp);
      test_done();
    end
  endtask

  task automatic settle_chk(input logic exp);
    repeat (10) @(posedge clk);
    #1;
    check(16'(en6), 16'(exp));
  endtask

  // Delay of n edges against nominal ms, ten percent plus pipeline slack
  task automatic chk_dly(input int cnt, input int ms, input int extra);
    int nom;
    nom = (ms == 0) ? 1 : ms * P;
    check(((cnt >= nom - nom / 10) && (cnt <= nom + nom / 10 + extra)) ? 16'(nom) : 16'(cnt), 16'(nom));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(8'h15 + 8'(i), d);
      check(16'(d), 16'(OTP_A[8*i +: 8]));
    end
    reg_wr(8'h20, 8'hFF);
    reg_rd(8'h20, d);
    check(16'(d), 16'h0000);
    check(16'(step), 16'h0001);
  endtask

  task automatic t_reg_rw;
    for (int i = 0; i < 4; i++)
      reg_wr(8'h15 + 8'(i), i[0] ? 8'h5A : 8'hA5);
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(8'h15 + 8'(i), d);
      check(16'(d), i[0] ? 16'h005A : 16'h00A5);
    end
  endtask

  task automatic t_rail5_delays;
    host.drive(6'h00, 10'h3FF, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(RAIL5_DELAY_OFS, {2'b00, 3'(c), 3'(c)});
      host.drive(6'h00, 10'h3FF, 1'b1);
      wait_en(1'b0, 1'b1, 800, n);
      chk_dly(n, int'(DLY_MS_TBL[c]), 2);
      host.drive(6'h00, 10'h3FF, 1'b0);
      wait_en(1'b0, 1'b0, 800, n);
      chk_dly(n, int'(DLY_MS_TBL[c]), 2);
    end
  endtask

  task automatic t_rail6_source;
    logic [5:0] need [0:7];
    need = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
    reg_wr(RAIL6_DELAY_OFS, 8'h00);
    reg_wr(RAIL6_MASK_OFS, 8'hFF);
    for (int c = 0; c < 8; c++)
    begin
      host.drive(6'h00, 10'h000, 1'b0);
      reg_wr(RAIL6_SOURCE_OFS, {3'b001, 3'(c), 2'b11});
      host.drive((c == 5) ? 6'h04 : 6'h00, 10'h000, 1'b0);
      settle_chk(c == 7);
      host.drive(need[c], 10'h000, 1'b0);
      wait_en(1'b1, 1'b1, 12, n);
      host.drive(~need[c], 10'h000, 1'b0);
      wait_en(1'b1, c == 7, 12, n);
    end
  endtask

  task automatic t_rail6_mask;
    for (int i = 0; i < 10; i++)
    begin
      reg_wr(RAIL6_MASK_OFS, 8'h00);
      reg_wr(RAIL6_SOURCE_OFS, 8'h3C);
      host.drive(6'h00, ~(10'h001 << i), 1'b0);
      settle_chk(1'b0);
      if (i < 8)
        reg_wr(RAIL6_MASK_OFS, 8'h01 << i);
      else
        reg_wr(RAIL6_SOURCE_OFS, {6'h0F, i == 9, i == 8});
      wait_en(1'b1, 1'b1, 12, n);
    end
  endtask

  task automatic t_rail6_rise;
    reg_wr(RAIL6_DELAY_OFS, 8'h01);
    reg_wr(RAIL6_SOURCE_OFS, 8'h3C);
    host.drive(6'h00, 10'h1FF, 1'b0);
    wait_en(1'b1, 1'b0, 12, n);
    host.drive(6'h00, 10'h3FF, 1'b0);
    wait_en(1'b1, 1'b1, 60, n);
    chk_dly(n, 2, 4);
    reg_rd(STATUS_OFS, d);
    check(16'(d), 16'h0006);
    // Two ms fall, read while the count runs so the pending bit shows
    reg_wr(RAIL6_DELAY_OFS, 8'h09);
    host.drive(6'h00, 10'h1FF, 1'b0);
    repeat (4) @(posedge clk);
    reg_rd(STATUS_OFS, d);
    check(16'(d), 16'h0012);
    wait_en(1'b1, 1'b0, 60, n);
  endtask

  task automatic t_step;
    do_reset(OTP_B);
    reg_rd(RAIL6_SOURCE_OFS, d);
    check(16'(d), 16'h0086);
    check(16'(step), 16'h0000);
    do_reset(OTP_A);
    #1;
    check(16'(step), 16'h0001);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    otp         = OTP_A;
    num_errors  = 0;
    checks_done = 0;
    do_reset(OTP_A);
    t_reset_values();
    t_reg_rw();
    t_rail5_delays();
    t_rail6_source();
    t_rail6_mask();
    t_rail6_rise();
    t_step();
    test_done();
  end
endmodule // tb_top
